// ==== sysctl_pkg.sv ====
package sysctl_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 4;                      // Byte address bits decoded
    localparam int DATA_W = 32;                     // Wishbone data width
    localparam int SEL_W = 4;                       // Byte lanes

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;      // Map and monitor control
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;    // Block state, one clearable flag
    localparam logic [ADDR_W-1:0] OFS_LUT_LO = 4'h8;    // Ratio table entries 0..7
    localparam logic [ADDR_W-1:0] OFS_LUT_HI = 4'hc;    // Ratio table entries 8..15

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTRL_MAP_LSB = 0;                // Software map choice, 2 bits
    localparam int CTRL_OVR_BIT = 2;                // Software map overrides strap
    localparam int CTRL_MON_BIT = 3;                // Monitor source: 1 bus clock, 0 PLL

    // ************************************************************
    // Status register fields
    // ************************************************************
    localparam int ST_MAPSTRAP_BIT = 0;             // Captured map strap
    localparam int ST_ROMW_BIT = 1;                 // Captured ROM bank 0 width strap
    localparam int ST_ROMLOC_BIT = 2;               // Captured ROM location strap
    localparam int ST_MAP_LSB = 3;                  // Active map, 2 bits
    localparam int ST_RATIO_LSB = 5;                // Active ratio code, 2 bits
    localparam int ST_BYPASS_BIT = 7;               // PLL bypass in force
    localparam int ST_SUSP_BIT = 8;                 // Suspend mode
    localparam int ST_QST_LSB = 9;                  // Quiesce state, 2 bits
    localparam int ST_MCP_BIT = 11;                 // Machine check asserted
    localparam int ST_IRQ_BIT = 12;                 // Unrecorded write flag, write 1 clears
    localparam int ST_ROM1_BIT = 13;                // ROM bank 1 is 64 bits wide

    // ************************************************************
    // Clock ratio lookup table
    // ************************************************************
    localparam int LUT_N = 16;                      // One entry per strap code
    localparam int LUT_ENT_W = 4;                   // Entry stride in a register
    localparam int LUT_PER_REG = 8;                 // Entries per register
    localparam int LUT_BYP_BIT = 2;                 // Bypass bit inside an entry

    // ************************************************************
    // Enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        MAP_A = 2'b00,                              // Address map A
        MAP_B = 2'b01,                              // Address map B
        MAP_EMU = 2'b10,                            // Emulation map, software only
        MAP_RSVD = 2'b11                            // Not a map
    } addr_map_t;

    typedef enum logic [1:0] {
        RATIO_1_1 = 2'b00,                          // Core equals reference
        RATIO_2_1 = 2'b01,                          // Core twice reference
        RATIO_3_1 = 2'b10,                          // Core thrice reference
        RATIO_RSVD = 2'b11                          // Not a ratio
    } ratio_t;

    typedef enum logic [1:0] {
        Q_RUN = 2'b00,                              // Normal operation
        Q_DRAIN = 2'b01,                            // Snoop traffic pausing
        Q_ACK = 2'b10                               // Quiesced, acknowledge given
    } qstate_t;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] LUT_ENTRY_RST = 3'h0;    // Every code 1:1, no bypass
    localparam logic [1:0] MAP_SEL_RST = 2'h0;      // Software map choice after reset
    localparam logic [1:0] MON_DIV_RST = 2'h0;      // Monitor divider start
    localparam int SYNC_W = 11;                     // Synchronised pin count

endpackage

// ==== sync2.sv ====
`timescale 1ns/100ps

// Two-stage synchroniser for a bus of independent pin levels
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] meta;                     // First stage, read only by second
        logic [WIDTH-1:0] stable;                   // Second stage
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // Next state: shift the pins through two stages
    always_comb begin
        s_next = s_reg;
        s_next.meta = async_i;
        s_next.stable = s_reg.meta;
        if (srst_i) begin
            s_next.meta = rst_val_i;
            s_next.stable = rst_val_i;
        end
    end

    // Register the state
    always_ff @(posedge ref_clk_i) begin
        s_reg <= s_next;
    end

    assign sync_o = s_reg.stable;

endmodule // sync2

// ==== bridge_system_control.sv ====
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps

module bridge_system_control (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sysctl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [sysctl_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [sysctl_pkg::DATA_W-1:0] wb_dat_i,
    output logic [sysctl_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins from the system, asynchronous
    input wire logic hard_reset_in_n_i,
    input wire logic fatal_error_n_i,
    input wire logic quiesce_request_n_i,
    input wire logic suspend_i,
    input wire logic map_select_strap_i,
    input wire logic rom0_width_strap_i,
    input wire logic rom_location_strap_i,
    input wire logic [3:0] pll_cfg_strap_i,
    // Core side, same clock
    input wire logic snoop_idle_i,
    input wire logic pci_unrecorded_write_i,
    // Pins to the system
    output logic machine_check_out_n_o,
    output logic quiesce_ack_n_o,
    output logic clock_monitor_out_o,
    output logic unrecorded_write_irq_o,
    output logic pins_oe_n_o,
    // Core configuration outputs
    output logic snoop_pause_o,
    output logic low_power_o,
    output logic suspended_o,
    output logic refresh_keep_o,
    output logic [1:0] pll_ratio_o,
    output logic pll_bypass_o,
    output logic [1:0] active_map_o,
    output logic rom0_8bit_o,
    output logic rom1_64bit_o,
    output logic rom_on_cpu_bus_o
);
    import sysctl_pkg::*;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [SYNC_W-1:0] pins_raw;                    // Pins gathered
    logic [SYNC_W-1:0] pins_rst;                    // Inactive levels for reset
    logic [SYNC_W-1:0] pins_s;                      // Pins after two flops

    assign pins_raw = {pll_cfg_strap_i, rom_location_strap_i, rom0_width_strap_i,
                       map_select_strap_i, suspend_i, quiesce_request_n_i,
                       fatal_error_n_i, hard_reset_in_n_i};
    assign pins_rst = {4'h0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1};

    // Control pins sit at the low end of the pin word, straps above them
    localparam int CTL_W = 4;

    // Control pins: held at their inactive levels during system reset
    sync2 #(.WIDTH(CTL_W)) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .async_i(pins_raw[CTL_W-1:0]),
        .rst_val_i(pins_rst[CTL_W-1:0]),
        .sync_o(pins_s[CTL_W-1:0])
    );

    // Straps: never forced, so a system reset captures the real pin levels
    sync2 #(.WIDTH(SYNC_W-CTL_W)) u_strap_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(1'b0),
        .async_i(pins_raw[SYNC_W-1:CTL_W]),
        .rst_val_i(pins_rst[SYNC_W-1:CTL_W]),
        .sync_o(pins_s[SYNC_W-1:CTL_W])
    );

    logic hard_reset_in_s;                                   // Hard reset, active high
    logic fatal_s;                                  // Fatal error, active high
    logic quiesce_request_s;                                   // Quiesce request, active high
    logic susp_s;                                   // Suspend level
    logic map_strap_s;                              // Map strap level
    logic romw_strap_s;                             // ROM width strap level
    logic romloc_strap_s;                           // ROM location strap level
    logic [3:0] pll_s;                              // Ratio strap code

    assign hard_reset_in_s = ~pins_s[0];
    assign fatal_s = ~pins_s[1];
    assign quiesce_request_s = ~pins_s[2];
    assign susp_s = pins_s[3];
    assign map_strap_s = pins_s[4];
    assign romw_strap_s = pins_s[5];
    assign romloc_strap_s = pins_s[6];
    assign pll_s = pins_s[10:7];

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic ack;                                  // Bus acknowledge
        logic [DATA_W-1:0] rdata;                   // Bus read data
        addr_map_t map_sel;                         // Software map choice
        logic map_ovr;                              // Software map in force
        logic mon_bus;                              // Monitor shows bus clock
        logic [LUT_N-1:0][2:0] lut;                 // Strap code to ratio and bypass
        logic map_strap;                            // Captured map strap
        logic romw_strap;                           // Captured width strap
        logic romloc_strap;                         // Captured location strap
        qstate_t qst;                               // Quiesce sequence
        logic irq;                                  // Unrecorded write flag
        logic machine_check_out;                                  // Machine check active
        logic susp;                                 // Suspend mode
        ratio_t ratio;                              // Ratio driven to PLL
        logic bypass;                               // Bypass driven to PLL
        addr_map_t map;                             // Active map
        logic [1:0] mon_div;                        // Monitor divider count
        logic mon;                                  // Monitor output level
        logic oe_n;                                 // Pins released when high
        logic mcp_n;                                // Machine check pin, low active
        logic quiesce_ack_n;                               // Quiesce acknowledge pin, low active
        logic pause;                                // Snoop pause to the core
        logic lp;                                   // Low power flag to the core
        logic rom1_wide;                            // ROM bank 1 width flag
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;

    // ************************************************************
    // Helpers
    // ************************************************************
    logic int_rst;                                  // Complete internal reset
    logic bus_req;                                  // New bus request this cycle
    logic wr_req;                                   // Bus write this cycle
    logic [2:0] lut_ent;                            // Entry for present strap code
    logic [DATA_W-1:0] status_word;                 // Status register image
    logic [DATA_W-1:0] lut_lo_word;                 // Table, low half image
    logic [DATA_W-1:0] lut_hi_word;                 // Table, high half image
    logic [DATA_W-1:0] ctrl_word;                   // Control register image

    // Suspend ignores the hard reset pin; system reset always acts
    assign int_rst = srst_i | (hard_reset_in_s & ~s_reg.susp);
    assign bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr_req = bus_req & wb_we_i;
    assign lut_ent = s_reg.lut[pll_s];

    // Register images for reading
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_MAP_LSB +: 2] = s_reg.map_sel;
        ctrl_word[CTRL_OVR_BIT] = s_reg.map_ovr;
        ctrl_word[CTRL_MON_BIT] = s_reg.mon_bus;
        status_word = '0;
        status_word[ST_MAPSTRAP_BIT] = s_reg.map_strap;
        status_word[ST_ROMW_BIT] = s_reg.romw_strap;
        status_word[ST_ROMLOC_BIT] = s_reg.romloc_strap;
        status_word[ST_MAP_LSB +: 2] = s_reg.map;
        status_word[ST_RATIO_LSB +: 2] = s_reg.ratio;
        status_word[ST_BYPASS_BIT] = s_reg.bypass;
        status_word[ST_SUSP_BIT] = s_reg.susp;
        status_word[ST_QST_LSB +: 2] = s_reg.qst;
        status_word[ST_MCP_BIT] = s_reg.machine_check_out;
        status_word[ST_IRQ_BIT] = s_reg.irq;
        status_word[ST_ROM1_BIT] = 1'b1;
        lut_lo_word = '0;
        lut_hi_word = '0;
        for (int i = 0; i < LUT_PER_REG; i++) begin
            lut_lo_word[i*LUT_ENT_W +: 3] = s_reg.lut[i];
            lut_hi_word[i*LUT_ENT_W +: 3] = s_reg.lut[i+LUT_PER_REG];
        end
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_next = s_reg;

        // Bus: answer every request one cycle later, unmapped reads zero
        s_next.ack = bus_req;
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL: s_next.rdata = ctrl_word;
                OFS_STATUS: s_next.rdata = status_word;
                OFS_LUT_LO: s_next.rdata = lut_lo_word;
                OFS_LUT_HI: s_next.rdata = lut_hi_word;
                default: s_next.rdata = '0;
            endcase
        end

        // Bus writes, low byte lane carries the control bits
        if (wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
            if (addr_map_t'(wb_dat_i[CTRL_MAP_LSB +: 2]) != MAP_RSVD) begin
                s_next.map_sel = addr_map_t'(wb_dat_i[CTRL_MAP_LSB +: 2]);
            end
            s_next.map_ovr = wb_dat_i[CTRL_OVR_BIT];
            s_next.mon_bus = wb_dat_i[CTRL_MON_BIT];
        end
        // Table writes, each byte lane holds two entries
        for (int i = 0; i < LUT_PER_REG; i++) begin
            if (wr_req && wb_adr_i == OFS_LUT_LO && wb_sel_i[i/2]) begin
                s_next.lut[i] = wb_dat_i[i*LUT_ENT_W +: 3];
            end
            if (wr_req && wb_adr_i == OFS_LUT_HI && wb_sel_i[i/2]) begin
                s_next.lut[i+LUT_PER_REG] = wb_dat_i[i*LUT_ENT_W +: 3];
            end
        end

        // Suspend follows its pin
        s_next.susp = susp_s;
        // Outputs float in suspend
        s_next.oe_n = susp_s;

        // Fatal error, frozen while suspended
        if (!s_reg.susp) begin
            s_next.machine_check_out = fatal_s;
        end

        // Ratio straps followed every cycle, no reset needed
        s_next.ratio = ratio_t'(lut_ent[1:0]);
        if (lut_ent[1:0] == RATIO_RSVD) begin
            s_next.ratio = RATIO_1_1;
        end
        s_next.bypass = lut_ent[LUT_BYP_BIT];

        // Active map, emulation reachable only from software
        s_next.map = s_reg.map_strap ? MAP_A : MAP_B;
        if (s_reg.map_ovr) begin
            s_next.map = s_reg.map_sel;
        end

        // Quiesce sequence, inputs ignored in suspend
        if (!s_reg.susp) begin
            unique case (s_reg.qst)
                Q_RUN: begin
                    if (quiesce_request_s) begin
                        s_next.qst = Q_DRAIN;
                    end
                end
                Q_DRAIN: begin
                    if (!quiesce_request_s) begin
                        s_next.qst = Q_RUN;
                    end else if (snoop_idle_i) begin
                        s_next.qst = Q_ACK;
                    end
                end
                Q_ACK: begin
                    if (!quiesce_request_s) begin
                        s_next.qst = Q_RUN;
                    end
                end
                default: s_next.qst = Q_RUN;
            endcase
        end

        // Unrecorded write flag, set wins over the clearing write
        if (wr_req && wb_adr_i == OFS_STATUS && wb_sel_i[1] && wb_dat_i[ST_IRQ_BIT]) begin
            s_next.irq = 1'b0;
        end
        if (pci_unrecorded_write_i && s_reg.map == MAP_EMU && !s_reg.susp) begin
            s_next.irq = 1'b1;
        end

        // Clock monitor: bus clock toggles each cycle, PLL view by ratio
        s_next.mon_div = s_reg.mon_div + 2'h1;
        if (s_reg.mon_bus || s_reg.mon_div >= 2'(s_reg.ratio)) begin
            s_next.mon_div = MON_DIV_RST;
            s_next.mon = ~s_reg.mon;
        end

        // Complete reset: capture straps, release pins, clear all
        if (int_rst) begin
            s_next = '0;
            s_next.oe_n = 1'b1;
            s_next.map_sel = addr_map_t'(MAP_SEL_RST);
            s_next.lut = {LUT_N{LUT_ENTRY_RST}};
            s_next.map_strap = map_strap_s;
            s_next.romw_strap = romw_strap_s;
            s_next.romloc_strap = romloc_strap_s;
            s_next.map = map_strap_s ? MAP_A : MAP_B;
            s_next.susp = 1'b0;
            s_next.ratio = RATIO_1_1;
            s_next.mon_div = MON_DIV_RST;
            s_next.ack = 1'b0;
        end

        // Pin images taken from the next state, so every output leaves a flop
        s_next.mcp_n = ~s_next.machine_check_out;
        s_next.quiesce_ack_n = (s_next.qst != Q_ACK);
        s_next.pause = (s_next.qst != Q_RUN);
        s_next.lp = (s_next.qst == Q_ACK);
        s_next.rom1_wide = 1'b1;
    end

    // Register the state
    always_ff @(posedge ref_clk_i) begin
        s_reg <= s_next;
    end

    // ************************************************************
    // Outputs, all from the state register
    // ************************************************************
    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign machine_check_out_n_o = s_reg.mcp_n;
    assign quiesce_ack_n_o = s_reg.quiesce_ack_n;
    assign clock_monitor_out_o = s_reg.mon;
    assign unrecorded_write_irq_o = s_reg.irq;
    assign pins_oe_n_o = s_reg.oe_n;
    assign snoop_pause_o = s_reg.pause;
    assign low_power_o = s_reg.lp;
    assign suspended_o = s_reg.susp;
    assign refresh_keep_o = s_reg.susp;
    assign pll_ratio_o = s_reg.ratio;
    assign pll_bypass_o = s_reg.bypass;
    assign active_map_o = s_reg.map;
    assign rom0_8bit_o = s_reg.romw_strap;
    assign rom1_64bit_o = s_reg.rom1_wide;
    assign rom_on_cpu_bus_o = s_reg.romloc_strap;

endmodule // bridge_system_control

// ==== bridge_system_control_asserts.sv ====
`timescale 1ns/100ps
// Watches the pin-level behaviour of the system-control block
module bridge_system_control_asserts (
    // Clock, reset, bus answer and pins in
    input wire logic ref_clk_i, srst_i, wb_ack_o, hard_reset_in_n_i, fatal_error_n_i,
    input wire logic quiesce_request_n_i, suspend_i, map_select_strap_i, snoop_idle_i,
    // Unrecorded write in, pins and core flags out
    input wire logic pci_unrecorded_write_i, machine_check_out_n_o, quiesce_ack_n_o,
    input wire logic unrecorded_write_irq_o, pins_oe_n_o, snoop_pause_o, low_power_o,
    input wire logic suspended_o, refresh_keep_o,
    input wire logic [1:0] active_map_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    reset_quiet_a: assert property (disable iff (1'b0) srst_i |=> pins_oe_n_o && machine_check_out_n_o
        && quiesce_ack_n_o && !wb_ack_o) else $error("output active in reset");
    map_strap_a: assert property ($past(srst_i) |-> active_map_o == {1'b0, !map_select_strap_i})
        else $error("map after reset");
    fatal_mcp_a: assert property ((!fatal_error_n_i && !suspend_i && hard_reset_in_n_i) [*5]
        |-> !machine_check_out_n_o) else $error("no machine check");
    pause_req_a: assert property ((!quiesce_request_n_i && !suspend_i && hard_reset_in_n_i) [*5]
        |-> snoop_pause_o) else $error("no snoop pause");
    quiesce_ack_cause_a: assert property ($fell(quiesce_ack_n_o) |-> $past(snoop_idle_i) && $past(snoop_pause_o))
        else $error("ack before drain");
    quiesce_ack_hold_a: assert property (!quiesce_ack_n_o && !quiesce_request_n_i && hard_reset_in_n_i
        |=> !quiesce_ack_n_o) else $error("ack dropped early");
    lp_match_a: assert property (low_power_o == !quiesce_ack_n_o) else $error("low power mismatch");
    susp_float_a: assert property (suspended_o |-> pins_oe_n_o && refresh_keep_o) else $error("suspend pins");
    irq_emu_a: assert property (pci_unrecorded_write_i && active_map_o == 2'h2 && !suspended_o
        |=> unrecorded_write_irq_o) else $error("irq missing");
    // Main scenarios reached
    cover property (!quiesce_ack_n_o);
    cover property ($rose(unrecorded_write_irq_o));
    cover property (suspended_o);
endmodule // bridge_system_control_asserts

bind bridge_system_control bridge_system_control_asserts chk (.*);

// ==== quiesce_request_host.sv ====
`timescale 1ns/100ps
// Processor side of quiesce: asks, drains snoops, lets go once answered
module quiesce_request_host (
    input wire logic ref_clk_i, start_i, slow_i, quiesce_ack_n_i,
    output logic quiesce_request_n_o, snoop_idle_o
);
    int cnt;
    initial begin
        quiesce_request_n_o = 1'b1;
        snoop_idle_o = 1'b1;
        cnt = 0;
    end
    // Snoop traffic ends after a short or a long delay
    always @(posedge ref_clk_i) begin
        if (start_i) begin
            quiesce_request_n_o <= 1'b0;
            snoop_idle_o <= 1'b0;
            cnt <= slow_i ? 9 : 1;
        end else if (!quiesce_ack_n_i) begin
            quiesce_request_n_o <= 1'b1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            snoop_idle_o <= 1'b1;
        end
    end
endmodule // quiesce_request_host

// ==== bridge_system_control_test.sv ====
`timescale 1ns/100ps
module bridge_system_control_test;
    import sysctl_pkg::*;
    logic ref_clk_i = 0, srst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, m, go = 0, slow = 0;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0, pll_cfg_strap_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic hard_reset_in_n_i = 1, fatal_error_n_i = 1, suspend_i = 0, pci_unrecorded_write_i = 0;
    logic map_select_strap_i = 1, rom0_width_strap_i = 0, rom_location_strap_i = 1;
    logic quiesce_request_n_i, snoop_idle_i, machine_check_out_n_o, quiesce_ack_n_o, clock_monitor_out_o;
    logic unrecorded_write_irq_o, pins_oe_n_o, snoop_pause_o, low_power_o, suspended_o, refresh_keep_o;
    logic pll_bypass_o, rom0_8bit_o, rom1_64bit_o, rom_on_cpu_bus_o;
    logic [1:0] pll_ratio_o, active_map_o;
    logic [2:0] st;
    integer seed = 32'hd225, miscompares = 0, cmp_count = 0, i, n;
    always #5 ref_clk_i = ~ref_clk_i;
    bridge_system_control uut (.*);
    quiesce_request_host host (.ref_clk_i, .start_i(go), .slow_i(slow), .quiesce_ack_n_i(quiesce_ack_n_o),
        .quiesce_request_n_o(quiesce_request_n_i), .snoop_idle_o(snoop_idle_i));
    task print_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task expire;
        if (n >= 40) begin
            miscompares++;
            print_verdict;
        end
    endtask
    // One classic bus cycle, held until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge ref_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        expire;
    endtask
    // Ratio table entry chosen for each strap code
    function automatic logic [2:0] ent(input int c);
        return {c == 5 || c == 12, c == 15 ? 2'h3 : 2'(c % 3)};
    endfunction
    function automatic logic [31:0] lutw(input int r);
        for (int k = 0; k < 8; k++) lutw[4*k +: 4] = {1'b0, ent(8 * r + k)};
    endfunction
    initial begin
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 0;
        @(posedge ref_clk_i);
        for (i = 0; i < 4; i++) begin
            st = 3'($random(seed));
            {map_select_strap_i, rom0_width_strap_i, rom_location_strap_i} <= st;
            srst_i <= 1;
            repeat (5) @(posedge ref_clk_i);
            srst_i <= 0;
            @(posedge ref_clk_i);
            {map_select_strap_i, rom0_width_strap_i, rom_location_strap_i} <= ~st;
            wb(0, OFS_STATUS, 4'hf, 0);
            chk(q[2:0], {st[0], st[1], st[2]});
            chk({active_map_o, rom0_8bit_o, rom1_64bit_o, rom_on_cpu_bus_o}, {1'b0, !st[2], st[1], 1'b1, st[0]});
        end
        wb(1, OFS_LUT_LO, 4'hf, lutw(0));
        wb(1, OFS_LUT_HI, 4'hf, lutw(1));
        for (i = 0; i < 16; i++) begin
            pll_cfg_strap_i <= 4'(i);
            repeat (5) @(posedge ref_clk_i);
            chk({pll_bypass_o, pll_ratio_o}, i == 15 ? 3'h0 : ent(i));
        end
        wb(0, 4'h1, 4'hf, 0);
        chk(q, 0);
        for (i = 0; i < 4; i++) begin
            wb(1, OFS_CTRL, 4'h1, 32'(4 + i));
            @(posedge ref_clk_i);
            pci_unrecorded_write_i <= 1;
            @(posedge ref_clk_i);
            pci_unrecorded_write_i <= 0;
            @(posedge ref_clk_i);
            chk(active_map_o, i < 3 ? i : 2);
            chk(unrecorded_write_irq_o, i >= 2);
            wb(1, OFS_STATUS, 4'h2, 32'h1000);
            chk(unrecorded_write_irq_o, 0);
        end
        wb(1, OFS_CTRL, 4'h1, 32'he);
        @(posedge ref_clk_i);
        m = clock_monitor_out_o;
        @(posedge ref_clk_i);
        chk(clock_monitor_out_o, !m);
        fatal_error_n_i <= 0;
        repeat (5) @(posedge ref_clk_i);
        chk(machine_check_out_n_o, 0);
        fatal_error_n_i <= 1;
        for (i = 0; i < 2; i++) begin
            {slow, go} <= {i[0], 1'b1};
            @(posedge ref_clk_i);
            go <= 0;
            for (n = 0; quiesce_ack_n_o !== 1'b0 && n < 40; n++) @(posedge ref_clk_i);
            expire;
            chk({snoop_pause_o, low_power_o}, 2'b11);
            for (n = 0; quiesce_ack_n_o !== 1'b1 && n < 40; n++) @(posedge ref_clk_i);
            expire;
            repeat (5) @(posedge ref_clk_i);
        end
        suspend_i <= 1;
        repeat (5) @(posedge ref_clk_i);
        hard_reset_in_n_i <= 0;
        repeat (5) @(posedge ref_clk_i);
        chk({suspended_o, refresh_keep_o, pins_oe_n_o, active_map_o}, 5'h1e);
        hard_reset_in_n_i <= 1;
        repeat (5) @(posedge ref_clk_i);
        suspend_i <= 0;
        repeat (5) @(posedge ref_clk_i);
        hard_reset_in_n_i <= 0;
        repeat (5) @(posedge ref_clk_i);
        chk({pins_oe_n_o, wb_ack_o, active_map_o}, {2'b10, 1'b0, st[2]});
        hard_reset_in_n_i <= 1;
        repeat (5) @(posedge ref_clk_i);
        print_verdict;
    end
endmodule // bridge_system_control_test
